// ---- charger_status_power_path.sv ----
// Status bits 7 to 11 and adapter/battery power-path selection of a charger.
// Assumes an APB master on clock; comparator inputs are asynchronous levels,
// battery voltage and die temperature are synchronous measurement words.
`timescale 1ns/1ps
// Operation
// - Adapter drives system and status bit 7 set when adapter present, not learning.
// - Battery drives system without adapter, or with adapter while learning.
// - Learning and battery below depleted threshold switches system to adapter.
// - Adapter overcurrent drops the adapter switch drive three clocks later, after the synchroniser and output register.
// - Status bit 8 high while charger held off by die overtemperature.
// - Shut down above 145 C with alarm; restart only below 130 C.
// - Register bus keeps working during thermal shutdown.
// - Status bit 9 high when thermistor is above the cold threshold.
// - Status bit 10 high when thermistor is below the hot threshold.
// - Hot threshold differs before charging and during charging.
// - Thermistor indications valid only while adapter is detected.
// - Status bit 11 high when battery below threshold from control bits 9-11.
// - Per-cell threshold scaled by three or four cells from voltage setting.
// - Depleted battery turns battery drive off; adapter on if was learning.
module charger_status_power_path #(
	parameter int MV_W = charger_status_pkg::MV_W,
	parameter int TEMP_W = charger_status_pkg::TEMP_W
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [charger_status_pkg::ADDR_W-1:0] paddr,
	input wire logic [charger_status_pkg::DATA_W-1:0] pwdata,
	output logic [charger_status_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic adapterDetectInput,
	input wire logic adapterOvercurrent,
	input wire logic thermistorAboveCold,
	input wire logic thermistorBelowHotStart,
	input wire logic thermistorBelowHotRun,
	input wire logic chargingActive,
	input wire logic [MV_W-1:0] batteryVoltageMv,
	input wire logic [TEMP_W-1:0] dieTemperature,
	output logic adapterSwitchDrive,
	output logic batterySwitchDrive,
	output logic chargerEnable,
	output logic thermalAlarm
);
	localparam int NSYNC = 6;

	logic [15:0] control_r;
	logic [MV_W-1:0] voltageSetting_r;
	logic [MV_W-1:0] batteryVoltage_r;
	logic [TEMP_W-1:0] dieTemp_r;
	logic learnDepleted_r;
	logic [NSYNC-1:0] rawComparators;
	logic [NSYNC-1:0] syncComparators;
	logic adapterPresent;
	logic overcurrent;
	logic senseCold;
	logic senseHotStart;
	logic senseHotRun;
	logic charging;
	logic thermalShutdown;
	logic thermalTrip;
	logic learnCycle;
	logic [2:0] cellCount;
	logic [MV_W-1:0] perCellMv;
	logic [MV_W-1:0] depletedThresholdMv;
	logic batteryDepleted;
	logic coldFlag;
	logic hotFlag;
	logic adapterDrive_nxt;
	logic batteryDrive_nxt;
	logic setupPhase;
	logic accessDone;
	logic writeDone;
	logic addrMapped;
	logic [15:0] statusWord;
	logic [charger_status_pkg::DATA_W-1:0] readValue;

	// Comparator synchronisers
	assign rawComparators = {chargingActive, thermistorBelowHotRun, thermistorBelowHotStart,
		thermistorAboveCold, adapterOvercurrent, adapterDetectInput};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : gSync
			level_sync uSync (
				.clock(clock),
				.reset(reset),
				.clockEnable(clockEnable),
				.asyncIn(rawComparators[gi]),
				.syncOut(syncComparators[gi])
			);
		end
	endgenerate

	assign adapterPresent = syncComparators[0];
	assign overcurrent = syncComparators[1];
	assign senseCold = syncComparators[2];
	assign senseHotStart = syncComparators[3];
	assign senseHotRun = syncComparators[4];
	assign charging = syncComparators[5];

	// Measurement words sampled once per cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			batteryVoltage_r <= '0;
			dieTemp_r <= '0;
		end else if (clockEnable) begin
			batteryVoltage_r <= batteryVoltageMv;
			dieTemp_r <= dieTemperature;
		end
	end

	thermal_hysteresis #(
		.TEMP_W(TEMP_W),
		.TRIP(charger_status_pkg::SHUTDOWN_C),
		.RELEASE(charger_status_pkg::RESTART_C)
	) uThermal (
		.clock(clock),
		.reset(reset),
		.clockEnable(clockEnable),
		.dieTemp(dieTemp_r),
		.shutdown(thermalShutdown),
		.tripPulse(thermalTrip)
	);

	// Depleted threshold
	assign learnCycle = control_r[charger_status_pkg::LEARN_BIT];

	always_comb begin
		if (voltageSetting_r >= charger_status_pkg::FOUR_CELL_MIN_MV) begin
			cellCount = charger_status_pkg::CELLS_FOUR;
		end else begin
			cellCount = charger_status_pkg::CELLS_THREE;
		end
	end

	assign perCellMv = MV_W'(charger_status_pkg::DEPLETED_BASE_MV
		+ charger_status_pkg::DEPLETED_STEP_MV
		* control_r[charger_status_pkg::DEPLETED_LSB +: charger_status_pkg::DEPLETED_W]);
	assign depletedThresholdMv = MV_W'(perCellMv * cellCount);
	assign batteryDepleted = batteryVoltage_r < depletedThresholdMv;

	// Thermistor flags, gated by the adapter-backed reference
	assign coldFlag = adapterPresent && senseCold;
	assign hotFlag = adapterPresent && (charging ? senseHotRun : senseHotStart);

	// Learn cycle ended by a depleted battery
	always_ff @(posedge clock) begin
		if (reset) begin
			learnDepleted_r <= 1'b0;
		end else if (clockEnable) begin
			if (!learnCycle || !adapterPresent) begin
				learnDepleted_r <= 1'b0;
			end else if (batteryDepleted) begin
				learnDepleted_r <= 1'b1;
			end
		end
	end

	// Power-path selection
	always_comb begin
		adapterDrive_nxt = adapterPresent && (!learnCycle || learnDepleted_r
			|| batteryDepleted);
		if (overcurrent) begin
			adapterDrive_nxt = 1'b0;
		end
		batteryDrive_nxt = (!adapterPresent || (learnCycle && !learnDepleted_r))
			&& !batteryDepleted;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			adapterSwitchDrive <= 1'b0;
			batterySwitchDrive <= 1'b0;
		end else if (clockEnable) begin
			adapterSwitchDrive <= adapterDrive_nxt;
			batterySwitchDrive <= batteryDrive_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			chargerEnable <= 1'b0;
			thermalAlarm <= 1'b0;
		end else if (clockEnable) begin
			chargerEnable <= !thermalShutdown;
			thermalAlarm <= thermalTrip;
		end
	end

	// Status word
	always_comb begin
		statusWord = '0;
		statusWord[charger_status_pkg::ST_ADAPTER_BIT] = adapterSwitchDrive;
		statusWord[charger_status_pkg::ST_THERMAL_BIT] = thermalShutdown;
		statusWord[charger_status_pkg::ST_COLD_BIT] = coldFlag;
		statusWord[charger_status_pkg::ST_HOT_BIT] = hotFlag;
		statusWord[charger_status_pkg::ST_DEPLETED_BIT] = batteryDepleted;
	end

	// APB slave, independent of thermal state
	assign setupPhase = psel && !penable;
	assign accessDone = psel && penable && pready;
	assign writeDone = accessDone && pwrite && addrMapped;

	always_comb begin
		addrMapped = 1'b1;
		readValue = '0;
		unique case (paddr)
			charger_status_pkg::CONTROL_ADDR: begin
				readValue[15:0] = control_r;
			end
			charger_status_pkg::VOLTAGE_ADDR: begin
				readValue[MV_W-1:0] = voltageSetting_r;
			end
			charger_status_pkg::STATUS_ADDR: begin
				readValue[15:0] = statusWord;
			end
			default: begin
				addrMapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (clockEnable) begin
			if (setupPhase) begin
				pready <= 1'b1;
				pslverr <= !addrMapped;
				prdata <= pwrite ? '0 : readValue;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			control_r <= charger_status_pkg::CONTROL_RESET;
			voltageSetting_r <= charger_status_pkg::VOLTAGE_RESET;
		end else if (clockEnable && writeDone) begin
			if (paddr == charger_status_pkg::CONTROL_ADDR) begin
				control_r <= pwdata[15:0] & charger_status_pkg::CONTROL_MASK;
			end
			if (paddr == charger_status_pkg::VOLTAGE_ADDR) begin
				voltageSetting_r <= pwdata[MV_W-1:0];
			end
		end
	end
endmodule : charger_status_power_path

// ---- charger_status_pkg.sv ----
// Constants shared by the charger status and power-path logic.
// Assumes a 32-bit APB slave with word-aligned registers.
package charger_status_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int MV_W = 16;
	localparam int TEMP_W = 8;

	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] CONTROL_IDX = 8'h12;
	localparam logic [ADDR_W-1:0] VOLTAGE_IDX = 8'h15;
	localparam logic [ADDR_W-1:0] STATUS_IDX = 8'h16;
	localparam logic [ADDR_W-1:0] CONTROL_ADDR = 8'h48;
	localparam logic [ADDR_W-1:0] VOLTAGE_ADDR = 8'h54;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h58;

	// Control register fields
	localparam int LEARN_BIT = 4;
	localparam int DEPLETED_LSB = 9;
	localparam int DEPLETED_W = 3;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_MASK = 16'h0e10;
	localparam logic [MV_W-1:0] VOLTAGE_RESET = 16'h0000;

	// Status register bit positions
	localparam int ST_ADAPTER_BIT = 7;
	localparam int ST_THERMAL_BIT = 8;
	localparam int ST_COLD_BIT = 9;
	localparam int ST_HOT_BIT = 10;
	localparam int ST_DEPLETED_BIT = 11;

	// Cell-count windows of the regulation voltage, in millivolts
	localparam logic [MV_W-1:0] THREE_CELL_MIN_MV = 16'd12000;
	localparam logic [MV_W-1:0] THREE_CELL_MAX_MV = 16'd14400;
	localparam logic [MV_W-1:0] FOUR_CELL_MIN_MV = 16'd16000;
	localparam logic [2:0] CELLS_THREE = 3'd3;
	localparam logic [2:0] CELLS_FOUR = 3'd4;

	// Per-cell depleted threshold: base plus code times step
	localparam logic [MV_W-1:0] DEPLETED_BASE_MV = 16'd2800;
	localparam logic [MV_W-1:0] DEPLETED_STEP_MV = 16'd100;

	// Die temperature limits in degrees Celsius
	localparam logic [TEMP_W-1:0] SHUTDOWN_C = 8'd145;
	localparam logic [TEMP_W-1:0] RESTART_C = 8'd130;

	localparam int SYNC_STAGES = 2;
endpackage : charger_status_pkg

// ---- level_sync.sv ----
// Two-flop synchroniser for one comparator level.
// Assumes the input is asynchronous to clock; the first flop feeds only the second.
`timescale 1ns/1ps
module level_sync (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic asyncIn,
	output logic syncOut
);
	logic meta_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			meta_r <= 1'b0;
			syncOut <= 1'b0;
		end else if (clockEnable) begin
			meta_r <= asyncIn;
			syncOut <= meta_r;
		end
	end
endmodule : level_sync

// ---- thermal_hysteresis.sv ----
// Die-temperature shutdown with trip and release limits.
// Assumes the temperature word is synchronous and in whole degrees Celsius.
`timescale 1ns/1ps
module thermal_hysteresis #(
	parameter int TEMP_W = 8,
	parameter logic [TEMP_W-1:0] TRIP = charger_status_pkg::SHUTDOWN_C,
	parameter logic [TEMP_W-1:0] RELEASE = charger_status_pkg::RESTART_C
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic [TEMP_W-1:0] dieTemp,
	output logic shutdown,
	output logic tripPulse
);
	always_ff @(posedge clock) begin
		if (reset) begin
			shutdown <= 1'b0;
			tripPulse <= 1'b0;
		end else if (clockEnable) begin
			tripPulse <= 1'b0;
			if (!shutdown && dieTemp > TRIP) begin
				shutdown <= 1'b1;
				tripPulse <= 1'b1;
			end else if (shutdown && dieTemp < RELEASE) begin
				shutdown <= 1'b0;
			end
		end
	end
endmodule : thermal_hysteresis

// ---- charger_status_power_path_assertions.sv ----
// Port checker for the charger status and power-path block.
// Assumes properties pause while clockEnable is low, since all state freezes then.
`timescale 1ns/1ps
module charger_status_power_path_assertions #(
	parameter int MV_W = 16,
	parameter int TEMP_W = 8
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic psel,
	input wire logic penable,
	input wire logic [charger_status_pkg::ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic adapterDetectInput,
	input wire logic adapterOvercurrent,
	input wire logic [MV_W-1:0] batteryVoltageMv,
	input wire logic [TEMP_W-1:0] dieTemperature,
	input wire logic adapterSwitchDrive,
	input wire logic batterySwitchDrive,
	input wire logic chargerEnable,
	input wire logic thermalAlarm
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset || !clockEnable);
	logic setup;
	logic mapped;
	assign setup = psel && !penable;
	assign mapped = paddr inside {charger_status_pkg::CONTROL_ADDR,
		charger_status_pkg::VOLTAGE_ADDR, charger_status_pkg::STATUS_ADDR};
	a_bus_in_shutdown: assert property (setup && !chargerEnable |=> pready)
		else $error("no bus answer in shutdown");
	a_unmapped_err: assert property (setup && !mapped |=> pready && pslverr)
		else $error("unmapped access not refused");
	a_oc_drops: assert property (adapterOvercurrent [*5] |-> !adapterSwitchDrive)
		else $error("adapter drive held in overcurrent");
	a_idle_adapter: assert property (!adapterDetectInput [*5] |-> !adapterSwitchDrive)
		else $error("adapter drive without adapter");
	a_drive_exclusive: assert property (!(adapterSwitchDrive && batterySwitchDrive))
		else $error("both switches driven");
	a_depleted_off: assert property ((batteryVoltageMv < 16'h20d0) [*4] |-> !batterySwitchDrive)
		else $error("battery drive kept when depleted");
	a_hot_trip: assert property ((dieTemperature > 8'h91) [*5] |-> !chargerEnable)
		else $error("charger on above trip");
	a_trip_holds: assert property ((dieTemperature >= 8'h82) [*4] ##0 thermalAlarm ##1
		(dieTemperature >= 8'h82) [*6] |-> !chargerEnable)
		else $error("early restart");
	a_alarm_pulse: assert property (thermalAlarm |=> !thermalAlarm)
		else $error("alarm longer than one cycle");
	cover property (thermalAlarm);
	cover property (setup && !mapped);
	cover property (adapterSwitchDrive && !batterySwitchDrive && adapterDetectInput);
endmodule : charger_status_power_path_assertions
bind charger_status_power_path charger_status_power_path_assertions #(
	.MV_W(MV_W), .TEMP_W(TEMP_W)
) chk (.clock, .reset, .clockEnable, .psel, .penable, .paddr, .pready, .pslverr,
	.adapterDetectInput,
	.adapterOvercurrent, .batteryVoltageMv, .dieTemperature, .adapterSwitchDrive,
	.batterySwitchDrive, .chargerEnable, .thermalAlarm);

// ---- host_apb_model.sv ----
// Host bus master model: one APB transfer at a time.
// Assumes the slave answers with pready; waits as long as that takes.
`timescale 1ns/1ps
module host_apb_model (
	input wire logic clock,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [charger_status_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	task automatic xfer(input logic w, input logic [charger_status_pkg::ADDR_W-1:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : host_apb_model

// ---- charger_status_power_path_bench.sv ----
// Self-checking bench for the charger status and power-path block.
// Assumes all register traffic goes through the host model.
`timescale 1ns/1ps
module charger_status_power_path_bench;
	localparam logic [7:0] CTL = charger_status_pkg::CONTROL_ADDR;
	localparam logic [7:0] VLT = charger_status_pkg::VOLTAGE_ADDR;
	localparam logic [7:0] STS = charger_status_pkg::STATUS_ADDR;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic clockEnable = 1'b1;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic adapterDetectInput = 1'b0;
	logic adapterOvercurrent = 1'b0;
	logic thermistorAboveCold = 1'b1;
	logic thermistorBelowHotStart = 1'b1;
	logic thermistorBelowHotRun = 1'b0;
	logic chargingActive = 1'b0;
	logic [15:0] batteryVoltageMv = 16'h3e80;
	logic [7:0] dieTemperature = 8'h19;
	logic adapterSwitchDrive, batterySwitchDrive, chargerEnable, thermalAlarm;
	int err_total = 0;
	int num_checks = 0;
	int cycles = 0;
	always #50 clock = ~clock;
	host_apb_model host (.clock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	charger_status_power_path dut (.clock, .reset, .clockEnable, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .adapterDetectInput,
		.adapterOvercurrent, .thermistorAboveCold, .thermistorBelowHotStart,
		.thermistorBelowHotRun, .chargingActive, .batteryVoltageMv, .dieTemperature,
		.adapterSwitchDrive, .batterySwitchDrive, .chargerEnable, .thermalAlarm);
	task automatic close_out();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		logic e;
		host.xfer(1'b0, a, 32'h0, v, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic e;
		host.xfer(1'b1, a, d, v, e);
	endtask : wr
	function automatic logic [31:0] drv();
		return 32'({adapterSwitchDrive, batterySwitchDrive});
	endfunction : drv
	task automatic t_reset();
		logic [31:0] v;
		cyc(6);
		rd(CTL, v);
		check(v, 32'h0);
		rd(VLT, v);
		check(v, 32'h0);
		rd(STS, v);
		check(v, 32'h0);
		check(drv(), 32'h1);
		check(32'({chargerEnable, thermalAlarm}), 32'h2);
		batteryVoltageMv <= 16'h1f40;
		cyc(4);
		check(drv(), 32'h0);
		rd(STS, v);
		check(v, 32'h800);
		batteryVoltageMv <= 16'h3e80;
		cyc(4);
		check(drv(), 32'h1);
	endtask : t_reset
	task automatic t_adapter();
		logic [31:0] v;
		adapterDetectInput <= 1'b1;
		cyc(6);
		rd(STS, v);
		check(v, 32'h680);
		check(drv(), 32'h2);
		chargingActive <= 1'b1;
		cyc(6);
		rd(STS, v);
		check(v, 32'h280);
		thermistorAboveCold <= 1'b0;
		thermistorBelowHotRun <= 1'b1;
		cyc(6);
		rd(STS, v);
		check(v, 32'h480);
		thermistorBelowHotRun <= 1'b0;
	endtask : t_adapter
	task automatic t_overcurrent();
		logic [31:0] v;
		adapterOvercurrent <= 1'b1;
		cyc(4);
		check(32'(adapterSwitchDrive), 32'h0);
		rd(STS, v);
		check(v, 32'h0);
		adapterOvercurrent <= 1'b0;
		cyc(6);
		check(drv(), 32'h2);
	endtask : t_overcurrent
	task automatic t_learn();
		logic [31:0] v;
		wr(CTL, 32'hffff_f1ff);
		rd(CTL, v);
		check(v, 32'h10);
		batteryVoltageMv <= 16'h2134;
		cyc(6);
		check(drv(), 32'h1);
		batteryVoltageMv <= 16'h206c;
		cyc(4);
		rd(STS, v);
		check(v & 32'h800, 32'h800);
		check(drv(), 32'h2);
		batteryVoltageMv <= 16'h2710;
		cyc(4);
		rd(STS, v);
		check(v & 32'h800, 32'h0);
		check(drv(), 32'h2);
		wr(VLT, 32'h41a0);
		cyc(2);
		rd(STS, v);
		check(v & 32'h800, 32'h800);
		wr(CTL, 32'h0);
		wr(VLT, 32'h0);
		batteryVoltageMv <= 16'h3e80;
		cyc(6);
	endtask : t_learn
	task automatic t_thermal();
		int n;
		logic [31:0] v;
		dieTemperature <= 8'h91;
		cyc(6);
		check(32'(chargerEnable), 32'h1);
		dieTemperature <= 8'h96;
		n = 0;
		repeat (8) begin
			@(posedge clock);
			if (thermalAlarm === 1'b1) n++;
		end
		check(32'(n), 32'h1);
		rd(STS, v);
		check(v & 32'h100, 32'h100);
		dieTemperature <= 8'h82;
		cyc(8);
		check(32'(chargerEnable), 32'h0);
		dieTemperature <= 8'h81;
		cyc(5);
		check(32'(chargerEnable), 32'h1);
		rd(STS, v);
		check(v & 32'h100, 32'h0);
	endtask : t_thermal
	task automatic t_bus();
		logic [31:0] v;
		logic e;
		host.xfer(1'b0, 8'h40, 32'h0, v, e);
		check({31'h0, e}, 32'h1);
		wr(STS, 32'hffff);
		rd(STS, v);
		check(v, 32'h80);
	endtask : t_bus
	task automatic t_freeze();
		clockEnable <= 1'b0;
		adapterOvercurrent <= 1'b1;
		cyc(6);
		check(drv(), 32'h2);
		clockEnable <= 1'b1;
		cyc(4);
		check(drv(), 32'h0);
		adapterOvercurrent <= 1'b0;
		cyc(6);
		check(drv(), 32'h2);
	endtask : t_freeze
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_adapter();
		t_overcurrent();
		t_learn();
		t_thermal();
		t_bus();
		t_freeze();
		close_out();
	end
endmodule : charger_status_power_path_bench
